// [src/jpdc_top.v]
// APB register file and divider datapath for the first-stage PLL dividers
//
// Behaviour
// [R1] The 3-bit feedback lock phase selector resets to 000 and is output with the input selector.
// [R2] Software picks the feedback selector code from the primary ratio range, 010 up to 111; the code recommends 000 for ratios below 32.
// [R3] The primary feedback ratio is a 12-bit read/write binary divide value reset to 3072.
// [R4] The secondary feedback ratio is a 9-bit divide value reset to 96 that runs while enabled.
// [R5] Setting the secondary power-down bit stops and disables the secondary divider; reset 0.
// [R6] Software may power the secondary divider down when input clock monitors are unused.
// [R7] The 3-bit input lock phase selector resets to 000 and follows the prescale range map.
// [R8] The input prescale ratio is a 12-bit read/write binary divide value reset to 3072.
`timescale 1ns/1ps
`include "jpdc_defs.vh"
module jpdc_top (
    // Clock and reset
    input wire clk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`JPDC_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // Divider ticks
    input wire ref_tick,
    input wire fb_tick,
    output wire ref_div_tick,
    output wire fb_div_tick,
    output wire sec_div_tick,
    // Configuration outputs
    output wire [2:0] feedback_lock_phase_select,
    output wire [2:0] input_lock_phase_select,
    output wire [11:0] primary_feedback_ratio,
    output wire [8:0] secondary_feedback_ratio,
    output wire secondary_divider_powerdown,
    output wire [11:0] input_prescale_ratio
);

reg [2:0] fb_phase_reg;
reg [2:0] in_phase_reg;
reg [11:0] fb_ratio_reg;
reg [8:0] sec_ratio_reg;
reg sec_pd_reg;
reg [11:0] in_ratio_reg;
reg [31:0] rdata_next;
reg err_next;
reg [31:0] status_word;

wire setup;
wire access;
wire [2:0] idx;
wire idx_hit;
wire [7:0] wbyte;
wire [2:0] fb_code;
wire [2:0] in_code;
wire wr_en;
wire sec_enable;
wire fb_phase_off;
wire in_phase_off;

// Recommended lock phase code for a divide ratio
function [2:0] lock_code;
    input [11:0] ratio;
    begin
        if (ratio >= 12'h400) begin
            lock_code = 3'h7;
        end else if (ratio >= 12'h200) begin
            lock_code = 3'h6;
        end else if (ratio >= 12'h100) begin
            lock_code = 3'h5;
        end else if (ratio >= 12'h080) begin
            lock_code = 3'h4;
        end else if (ratio >= 12'h040) begin
            lock_code = 3'h3;
        end else if (ratio >= 12'h020) begin
            lock_code = 3'h2;
        end else begin
            lock_code = 3'h0;
        end
    end
endfunction

assign setup = psel && !penable;
assign access = psel && penable;
assign idx = paddr[4:2];
assign idx_hit = (paddr[1:0] == 2'h0) && (paddr[`JPDC_ADDR_W-1:5] == 7'h00) &&
    (idx <= `JPDC_IDX_STATUS);
assign wbyte = pwdata[7:0];
assign pready = 1'b1;

assign fb_code = lock_code(fb_ratio_reg);
assign in_code = lock_code(in_ratio_reg);
assign fb_phase_off = (fb_code != fb_phase_reg); // [R2]
assign in_phase_off = (in_code != in_phase_reg); // [R7]
assign wr_en = access && pwrite && idx_hit;

// Secondary divider runs only while not powered down
assign sec_enable = !sec_pd_reg; // [R5]

// Register writes take effect at the access edge
always @(posedge clk) begin
    if (rst) begin
        fb_phase_reg <= `JPDC_RST_PHASE; // [R1]
        in_phase_reg <= `JPDC_RST_PHASE; // [R7]
        fb_ratio_reg <= `JPDC_RST_FB_RATIO; // [R3]
        sec_ratio_reg <= `JPDC_RST_SEC_RATIO; // [R4]
        sec_pd_reg <= `JPDC_RST_PD; // [R5]
        in_ratio_reg <= `JPDC_RST_IN_RATIO; // [R8]
    end else if (wr_en) begin
        if (idx == `JPDC_IDX_CTRL0) begin
            fb_phase_reg <= wbyte[`JPDC_PHASE_MSB:`JPDC_PHASE_LSB]; // [R1]
            sec_pd_reg <= wbyte[`JPDC_PD_BIT]; // [R5]
            fb_ratio_reg[11:8] <= wbyte[`JPDC_HI_MSB:0]; // [R3]
        end else if (idx == `JPDC_IDX_FB_LO) begin
            fb_ratio_reg[7:0] <= wbyte; // [R3]
        end else if (idx == `JPDC_IDX_SEC_LO) begin
            sec_ratio_reg[7:0] <= wbyte; // [R4]
        end else if (idx == `JPDC_IDX_SEC_HI) begin
            sec_ratio_reg[8] <= wbyte[`JPDC_SEC_MSB_BIT]; // [R4]
        end else if (idx == `JPDC_IDX_IN_HI) begin
            in_phase_reg <= wbyte[`JPDC_PHASE_MSB:`JPDC_PHASE_LSB]; // [R7]
            in_ratio_reg[11:8] <= wbyte[`JPDC_HI_MSB:0]; // [R8]
        end else if (idx == `JPDC_IDX_IN_LO) begin
            in_ratio_reg[7:0] <= wbyte; // [R8]
        end
    end
end

// Read mux; reserved bits read as zero and a write to the status register is an error
always @* begin
    rdata_next = 32'h00000000;
    err_next = 1'b0;
    if (!idx_hit) begin
        err_next = 1'b1;
    end else if (idx == `JPDC_IDX_CTRL0) begin
        rdata_next[`JPDC_PHASE_MSB:`JPDC_PHASE_LSB] = fb_phase_reg;
        rdata_next[`JPDC_PD_BIT] = sec_pd_reg;
        rdata_next[`JPDC_HI_MSB:0] = fb_ratio_reg[11:8];
    end else if (idx == `JPDC_IDX_FB_LO) begin
        rdata_next[7:0] = fb_ratio_reg[7:0];
    end else if (idx == `JPDC_IDX_SEC_LO) begin
        rdata_next[7:0] = sec_ratio_reg[7:0];
    end else if (idx == `JPDC_IDX_SEC_HI) begin
        rdata_next[`JPDC_SEC_MSB_BIT] = sec_ratio_reg[8];
    end else if (idx == `JPDC_IDX_IN_HI) begin
        rdata_next[`JPDC_PHASE_MSB:`JPDC_PHASE_LSB] = in_phase_reg;
        rdata_next[`JPDC_HI_MSB:0] = in_ratio_reg[11:8];
    end else if (idx == `JPDC_IDX_IN_LO) begin
        rdata_next[7:0] = in_ratio_reg[7:0];
    end else begin
        rdata_next = status_word;
        if (pwrite) begin
            err_next = 1'b1;
        end
    end
end

// Recommended codes and whether the programmed selectors disagree
always @* begin
    status_word = 32'h00000000;
    status_word[`JPDC_ST_FB_CODE_LSB+2:`JPDC_ST_FB_CODE_LSB] = fb_code; // [R2]
    status_word[`JPDC_ST_IN_CODE_LSB+2:`JPDC_ST_IN_CODE_LSB] = in_code; // [R7]
    status_word[`JPDC_ST_FB_MISMATCH] = fb_phase_off; // [R2]
    status_word[`JPDC_ST_IN_MISMATCH] = in_phase_off; // [R7]
    status_word[`JPDC_ST_SEC_ACTIVE] = sec_enable; // [R5]
end

// Answer is captured in the setup cycle so it stands through the access cycle
always @(posedge clk) begin
    if (rst) begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
    end else if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rdata_next;
        pslverr <= err_next;
    end else if (!psel) begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
    end
end

assign feedback_lock_phase_select = fb_phase_reg; // [R1]
assign input_lock_phase_select = in_phase_reg; // [R7]
assign primary_feedback_ratio = fb_ratio_reg;
assign secondary_feedback_ratio = sec_ratio_reg;
assign secondary_divider_powerdown = sec_pd_reg;
assign input_prescale_ratio = in_ratio_reg;

// Input prescaler on the reference ticks
jpdc_divider #(.WIDTH(12)) u_in_div (
    .clk(clk),
    .rst(rst),
    .enable(1'b1),
    .ratio(in_ratio_reg), // [R8]
    .tick_in(ref_tick),
    .tick_out(ref_div_tick)
);

// Primary feedback divider
jpdc_divider #(.WIDTH(12)) u_fb_div (
    .clk(clk),
    .rst(rst),
    .enable(1'b1),
    .ratio(fb_ratio_reg), // [R3]
    .tick_in(fb_tick),
    .tick_out(fb_div_tick)
);

// Secondary divider cascaded after the primary; held cleared while powered down
jpdc_divider #(.WIDTH(9)) u_sec_div (
    .clk(clk),
    .rst(rst),
    .enable(sec_enable), // [R4] [R5]
    .ratio(sec_ratio_reg), // [R4]
    .tick_in(fb_div_tick),
    .tick_out(sec_div_tick)
);

endmodule

// [src/jpdc_defs.vh]
// Register indices, field positions and reset values of the PLL divider configuration
`ifndef JPDC_DEFS_VH
`define JPDC_DEFS_VH

// Register indices; byte address is four times the index
`define JPDC_IDX_CTRL0 3'h0
`define JPDC_IDX_FB_LO 3'h1
`define JPDC_IDX_SEC_LO 3'h2
`define JPDC_IDX_SEC_HI 3'h3
`define JPDC_IDX_IN_HI 3'h4
`define JPDC_IDX_IN_LO 3'h5
`define JPDC_IDX_STATUS 3'h6
`define JPDC_ADDR_W 12

// Field positions inside the byte registers
`define JPDC_PHASE_MSB 7
`define JPDC_PHASE_LSB 5
`define JPDC_PD_BIT 4
`define JPDC_HI_MSB 3
`define JPDC_SEC_MSB_BIT 7

// Status register fields
`define JPDC_ST_FB_CODE_LSB 0
`define JPDC_ST_IN_CODE_LSB 4
`define JPDC_ST_FB_MISMATCH 8
`define JPDC_ST_IN_MISMATCH 9
`define JPDC_ST_SEC_ACTIVE 10

// Reset values
`define JPDC_RST_PHASE 3'h0
`define JPDC_RST_FB_RATIO 12'hC00
`define JPDC_RST_SEC_RATIO 9'h060
`define JPDC_RST_PD 1'h0
`define JPDC_RST_IN_RATIO 12'hC00

`endif

// [src/jpdc_divider.v]
// Programmable tick divider used for each configured divide ratio
`timescale 1ns/1ps
module jpdc_divider #(
    parameter WIDTH = 12
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire enable,
    input wire [WIDTH-1:0] ratio,
    // Ticks
    input wire tick_in,
    output reg tick_out
);

reg [WIDTH-1:0] count_reg;
wire [WIDTH-1:0] count_inc;

assign count_inc = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};

always @(posedge clk) begin
    if (rst || !enable) begin
        count_reg <= {WIDTH{1'b0}};
        tick_out <= 1'b0;
    end else if (tick_in) begin
        // Wrap once the count reaches the ratio; ratio 0 passes every tick
        if (count_inc >= ratio) begin
            count_reg <= {WIDTH{1'b0}};
            tick_out <= 1'b1;
        end else begin
            count_reg <= count_inc;
            tick_out <= 1'b0;
        end
    end else begin
        tick_out <= 1'b0;
    end
end

endmodule

// [tb/jpdc_top_properties.sv]
// Concurrent checks on the divider configuration ports
`timescale 1ns/1ps
module jpdc_top_properties (
    // Clock and reset
    input wire clk,
    input wire rst,
    // APB request
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // Divider and configuration
    input wire sec_div_tick,
    input wire [2:0] feedback_lock_phase_select,
    input wire [2:0] input_lock_phase_select,
    input wire [11:0] primary_feedback_ratio,
    input wire [8:0] secondary_feedback_ratio,
    input wire secondary_divider_powerdown,
    input wire [11:0] input_prescale_ratio
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire wr = psel && penable && pwrite;
    property p_fb_ph_rst; $fell(rst) |-> feedback_lock_phase_select == 3'h0; endproperty
    a_fb_ph_rst: assert property (p_fb_ph_rst) else $error("feedback phase not cleared");
    property p_in_ph_rst; $fell(rst) |-> input_lock_phase_select == 3'h0; endproperty
    a_in_ph_rst: assert property (p_in_ph_rst) else $error("input phase not cleared");
    property p_ratio_rst;
        $fell(rst) |-> primary_feedback_ratio == 12'hC00 && input_prescale_ratio == 12'hC00;
    endproperty
    a_ratio_rst: assert property (p_ratio_rst) else $error("ratio reset wrong");
    property p_sec_rst;
        $fell(rst) |-> secondary_feedback_ratio == 9'h060 && !secondary_divider_powerdown;
    endproperty
    a_sec_rst: assert property (p_sec_rst) else $error("secondary reset wrong");
    property p_fb_wr;
        wr && paddr == 12'h004 |=> primary_feedback_ratio[7:0] == $past(pwdata[7:0]);
    endproperty
    a_fb_wr: assert property (p_fb_wr) else $error("primary low byte not written");
    property p_sec_wr;
        wr && paddr == 12'h008 |=> secondary_feedback_ratio[7:0] == $past(pwdata[7:0]);
    endproperty
    a_sec_wr: assert property (p_sec_wr) else $error("secondary low byte not written");
    property p_in_wr;
        wr && paddr == 12'h010 |=> {input_lock_phase_select, input_prescale_ratio[11:8]}
            == {$past(pwdata[7:5]), $past(pwdata[3:0])};
    endproperty
    a_in_wr: assert property (p_in_wr) else $error("input control not written");
    property p_pd_stop; secondary_divider_powerdown [*2] |-> !sec_div_tick; endproperty
    a_pd_stop: assert property (p_pd_stop) else $error("secondary ticks while down");
endmodule
bind jpdc_top jpdc_top_properties u_props (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .sec_div_tick(sec_div_tick), .feedback_lock_phase_select(feedback_lock_phase_select),
    .input_lock_phase_select(input_lock_phase_select),
    .primary_feedback_ratio(primary_feedback_ratio),
    .secondary_feedback_ratio(secondary_feedback_ratio),
    .secondary_divider_powerdown(secondary_divider_powerdown),
    .input_prescale_ratio(input_prescale_ratio));

// [tb/tb_top.sv]
// Self-checking bench for the divider configuration block
`timescale 1ns/1ps
module tb_top;
    reg clk, rst, psel, penable, pwrite, ref_tick, fb_tick, err;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    reg [7:0] m [0:5];
    reg [7:0] v;
    reg [11:0] ra, rb;
    reg [15:0] lfsr = 16'h003A;
    wire [31:0] prdata;
    wire pready, pslverr, rdt, fdt, sdt, pd;
    wire [2:0] fph, iph;
    wire [11:0] fr, ir;
    wire [8:0] sr;
    integer bad_count = 0, comparisons = 0, i, k, fc, sc, rc, tc;
    jpdc_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_tick(ref_tick), .fb_tick(fb_tick), .ref_div_tick(rdt), .fb_div_tick(fdt),
        .sec_div_tick(sdt), .feedback_lock_phase_select(fph), .input_lock_phase_select(iph),
        .primary_feedback_ratio(fr), .secondary_feedback_ratio(sr),
        .secondary_divider_powerdown(pd), .input_prescale_ratio(ir));
    function [15:0] step(input [15:0] s);
        step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Recommended lock phase code for a divide ratio; 1 to 31 is taken as 000
    function [2:0] rec_code(input [11:0] r);
        rec_code = (r >= 12'h400) ? 3'h7 : (r >= 12'h200) ? 3'h6 : (r >= 12'h100) ? 3'h5 :
            (r >= 12'h080) ? 3'h4 : (r >= 12'h040) ? 3'h3 : (r >= 12'h020) ? 3'h2 : 3'h0;
    endfunction
    task check(input [95:0] name, input [39:0] exp, input [39:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("wrong value %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [7:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= {24'h000000, d};
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask
    task run(input integer cyc, input ron);
        begin
            fc = 0; sc = 0; rc = 0; tc = 0;
            for (k = 0; k < cyc + 4; k = k + 1) begin
                lfsr = step(lfsr);
                fb_tick <= k < cyc;
                ref_tick <= ron && k < cyc && lfsr[0];
                tc = tc + (ron && k < cyc && lfsr[0]);
                @(posedge clk);
                fc = fc + fdt;
                sc = sc + sdt;
                rc = rc + rdt;
            end
        end
    endtask
    task summarize;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task reset_check;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                m[i] = 8'(48'h0C006000_0C00 >> (8 * (5 - i)));
                apb(1'b0, 12'(i * 4), 8'h00);
                check("reset rd", m[i], rd[7:0]);
            end
        end
    endtask
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    initial begin
        #50000;
        bad_count = bad_count + 1;
        summarize;
    end
    initial begin
        rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        ref_tick = 0; fb_tick = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        reset_check;
        for (i = 0; i < 24; i = i + 1) begin
            lfsr = step(lfsr);
            k = lfsr[10:8] % 6;
            v = (i < 6) ? 8'hFF : lfsr[7:0];
            m[k] = v & (k == 3 ? 8'h80 : k == 4 ? 8'hEF : 8'hFF);
            apb(1'b1, 12'(k * 4), v);
            apb(1'b0, 12'(k * 4), 8'h00);
            check("readback", {m[k], 1'b0}, {rd, err});
            check("config", {m[0], m[1], m[2], m[3][7], m[4][7:5], m[4][3:0], m[5]},
                {fph, pd, fr, sr[7:0], sr[8], iph, ir});
        end
        apb(1'b1, 12'h01C, 8'hFF);
        check("slverr", 1, err);
        apb(1'b1, 12'h000, 8'h00);
        apb(1'b1, 12'h004, 8'h03);
        apb(1'b1, 12'h008, 8'h04);
        apb(1'b1, 12'h00C, 8'h00);
        apb(1'b1, 12'h010, 8'h00);
        apb(1'b1, 12'h014, 8'h05);
        run(120, 1'b1);
        check("fb ticks", 40, fc);
        check("sec ticks", 10, sc);
        check("ref ticks", tc / 5, rc);
        apb(1'b1, 12'h000, 8'h10);
        run(120, 1'b0);
        check("fb ticks pd", 40, fc);
        check("sec ticks pd", 0, sc);
        // Selectors programmed from the ratios, some deliberately off by one code
        for (i = 0; i < 8; i = i + 1) begin
            lfsr = step(lfsr);
            ra = lfsr[11:0] >> lfsr[14:12];
            lfsr = step(lfsr);
            rb = lfsr[11:0] >> lfsr[14:12];
            apb(1'b1, 12'h000, {rec_code(ra) ^ {2'h0, i[1]}, i[0], ra[11:8]});
            apb(1'b1, 12'h004, ra[7:0]);
            apb(1'b1, 12'h010, {rec_code(rb) ^ {2'h0, i[2]}, 1'b0, rb[11:8]});
            apb(1'b1, 12'h014, rb[7:0]);
            apb(1'b0, 12'h018, 8'h00);
            check("status", {!i[0], i[2], i[1], 1'b0, rec_code(rb), 1'b0, rec_code(ra), 1'b0},
                {rd, err});
        end
        apb(1'b1, 12'h018, 8'hFF);
        check("status wr", 1, err);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reset_check;
        summarize;
    end
endmodule
